// >>> common/scw_pkg.sv
package scw_pkg;
   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_STATUS = 6'h10;
   localparam logic [5:0] IDX_FORMAT = 6'h0e;
   localparam logic [5:0] IDX_ENABLES = 6'h0f;
   localparam logic [5:0] IDX_DATA = 6'h11;
   // format/wake register fields
   localparam int F_RX9 = 7;
   localparam int F_TX9 = 6;
   localparam int F_NINE = 4;
   localparam int F_WAKE = 3;
   localparam int F_POL = 2;
   localparam int F_PHA = 1;
   localparam int F_LAST = 0;
   localparam logic [7:0] FORMAT_RESET = 8'h00;
   // enables register fields
   localparam int E_TXIE = 7;
   localparam int E_TX_DONE_IRQ_EN = 6;
   localparam int E_RXIE = 5;
   localparam int E_LINE_QUIET_IRQ_EN = 4;
   localparam int E_TXON = 3;
   localparam int E_RXON = 2;
   localparam int E_SLEEP = 1;
   localparam int E_BRK = 0;
   localparam logic [7:0] ENABLES_RESET = 8'h00;
   // status register fields
   localparam int S_TXE = 7;
   localparam int S_TXD = 6;
   localparam int S_RXF = 5;
   localparam int S_QUIET = 4;
   localparam int S_OVR = 3;
   localparam int S_NOISE = 2;
   localparam int S_FRAME = 1;
   // bits per frame, including start and stop
   localparam logic [3:0] FRAME_BITS8 = 4'ha;
   localparam logic [3:0] FRAME_BITS9 = 4'hb;
   localparam logic [3:0] DATA_BITS8 = 4'h8;
   localparam logic [3:0] DATA_BITS9 = 4'h9;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [6:0] {
      TX_IDLE = 7'b0000001,
      TX_PRE = 7'b0000010,
      TX_BRK = 7'b0000100,
      TX_START = 7'b0001000,
      TX_DATA = 7'b0010000,
      TX_STOP = 7'b0100000,
      TX_MARK = 7'b1000000
   } scw_tx_type;
   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA = 4'b0100,
      RX_STOP = 4'b1000
   } scw_rx_type;
endpackage

// >>> core/scw_uart.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
module scw_uart #(
   parameter int BIT_CLKS = 16
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic serialInPin,
   output logic serialOutPin,
   output logic serialOutEn,
   output logic sclkOut,
   output logic sclkOutEn,
   output logic irqReq
);
   localparam int CW = $clog2(BIT_CLKS + 1);
   localparam logic [CW-1:0] LAST_CNT = CW'(BIT_CLKS - 1);
   localparam logic [CW-1:0] HALF_CNT = CW'(BIT_CLKS / 2);
   localparam logic [CW-1:0] MID_CNT = CW'(BIT_CLKS / 2 + 1);

   logic [7:0] fmt_q, ena_q, txData_q, rxData_q;
   logic rxNinth_q, txEmpty_q, txDone_q, rxFull_q, quiet_q, ovr_q;
   logic noise_q, frame_q, statRead_q, quietArm_q;
   logic [1:0] inSync_q;
   logic [2:0] samp_q;
   logic [3:0] frameBits, dataBits;
   logic nine, wake, txOn, rxOn, sleep, brk, txOnOld_q, preReq_q;
   logic wrFire, rdFire, wrStat, wrFmt, wrEna, wrData, rdStat, rdData;
   logic [5:0] wIdx, rIdx;

   assign nine = fmt_q[scw_pkg::F_NINE];
   assign wake = fmt_q[scw_pkg::F_WAKE];
   assign txOn = ena_q[scw_pkg::E_TXON];
   assign rxOn = ena_q[scw_pkg::E_RXON];
   assign sleep = ena_q[scw_pkg::E_SLEEP];
   assign brk = ena_q[scw_pkg::E_BRK];
   // one framing choice for both directions
   assign frameBits = nine ? scw_pkg::FRAME_BITS9 : scw_pkg::FRAME_BITS8;
   assign dataBits = nine ? scw_pkg::DATA_BITS9 : scw_pkg::DATA_BITS8;

   // ---------------- bus slave ----------------
   // address and data taken together; no new write until response drains
   assign awready = awvalid & wvalid & ~bvalid;
   assign wready = awready;
   assign arready = ~rvalid;
   assign wrFire = awvalid & wvalid & ~bvalid;
   assign rdFire = arvalid & ~rvalid;
   assign wIdx = awaddr[7:2];
   assign rIdx = araddr[7:2];
   assign wrFmt = wrFire & wstrb[0] & (wIdx == scw_pkg::IDX_FORMAT);
   assign wrEna = wrFire & wstrb[0] & (wIdx == scw_pkg::IDX_ENABLES);
   assign wrData = wrFire & wstrb[0] & (wIdx == scw_pkg::IDX_DATA);
   assign wrStat = wrFire & (wIdx == scw_pkg::IDX_STATUS);
   assign rdStat = rdFire & (rIdx == scw_pkg::IDX_STATUS);
   assign rdData = rdFire & (rIdx == scw_pkg::IDX_DATA);

   // write response one cycle after the write is taken
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         bvalid <= 1'b0;
         bresp <= scw_pkg::RESP_OKAY;
      end else if (wrFire) begin
         bvalid <= 1'b1;
         bresp <= (wrFmt | wrEna | wrData | wrStat | ~wstrb[0]) &&
            (wIdx == scw_pkg::IDX_FORMAT || wIdx == scw_pkg::IDX_ENABLES ||
             wIdx == scw_pkg::IDX_DATA || wIdx == scw_pkg::IDX_STATUS) ?
            scw_pkg::RESP_OKAY : scw_pkg::RESP_SLVERR;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // read data registered; unmapped reads give zero and an error
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= scw_pkg::RESP_OKAY;
      end else if (rdFire) begin
         rvalid <= 1'b1;
         rresp <= scw_pkg::RESP_OKAY;
         unique case (rIdx)
            scw_pkg::IDX_FORMAT:
               rdata <= {24'h0, rxNinth_q, fmt_q[6:0]};
            scw_pkg::IDX_ENABLES: rdata <= {24'h0, ena_q};
            scw_pkg::IDX_DATA: rdata <= {24'h0, rxData_q};
            scw_pkg::IDX_STATUS:
               rdata <= {24'h0, txEmpty_q, txDone_q, rxFull_q, quiet_q,
                  ovr_q, noise_q, frame_q, 1'b0};
            default: begin
               rdata <= 32'h0;
               rresp <= scw_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end

   // status read arms the clear; data access completes it
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         statRead_q <= 1'b0;
      end else if (rdStat) begin
         statRead_q <= 1'b1;
      end else if (rdData | wrData) begin
         statRead_q <= 1'b0;
      end
   end

   // ---------------- transmitter ----------------
   scw_pkg::scw_tx_type txState_q;
   logic [CW-1:0] txCnt_q;
   logic [3:0] txBit_q;
   logic [8:0] txShift_q;
   logic txTick, txLine_q, sclk_q, oe_q, pulse, txLoad, txIdleNow;

   // free-running bit timer keeps the serial clock on a fixed grid
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         txCnt_q <= '0;
      end else begin
         txCnt_q <= (txCnt_q == LAST_CNT) ? '0 : txCnt_q + 1'b1;
      end
   end
   assign txTick = (txCnt_q == LAST_CNT);
   assign txLoad = txTick & (txState_q == scw_pkg::TX_IDLE) & txOn & ~brk &
      ~preReq_q & ~txEmpty_q;
   assign txIdleNow = (txState_q == scw_pkg::TX_IDLE) & ~txLoad;

   // rising enable requests a preamble, even mid character
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         txOnOld_q <= 1'b0;
         preReq_q <= 1'b0;
      end else begin
         txOnOld_q <= txOn;
         if (txOn & ~txOnOld_q) begin
            preReq_q <= 1'b1;
         end else if (txTick & (txState_q == scw_pkg::TX_IDLE) & txOn &
               ~brk) begin
            preReq_q <= 1'b0;
         end
      end
   end

   // frame sequencer, steps only on bit boundaries
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         txState_q <= scw_pkg::TX_IDLE;
         txBit_q <= 4'h0;
         txShift_q <= 9'h1ff;
      end else if (txTick) begin
         unique case (txState_q)
            scw_pkg::TX_IDLE: begin
               txBit_q <= 4'h0;
               if (txOn & brk) begin
                  txState_q <= scw_pkg::TX_BRK;
               end else if (txOn & preReq_q) begin
                  txState_q <= scw_pkg::TX_PRE;
               end else if (txLoad) begin
                  txShift_q <= {fmt_q[scw_pkg::F_TX9], txData_q};
                  txState_q <= scw_pkg::TX_START;
               end
            end
            scw_pkg::TX_PRE: begin
               txBit_q <= txBit_q + 4'h1;
               if (txBit_q == frameBits - 4'h1) begin
                  txState_q <= scw_pkg::TX_IDLE;
               end
            end
            scw_pkg::TX_BRK: begin
               // whole blocks only; a cleared request ends at block end
               if (txBit_q == frameBits - 4'h1) begin
                  txBit_q <= 4'h0;
                  if (!brk) begin
                     txState_q <= scw_pkg::TX_MARK;
                  end
               end else begin
                  txBit_q <= txBit_q + 4'h1;
               end
            end
            scw_pkg::TX_MARK: txState_q <= scw_pkg::TX_IDLE;
            scw_pkg::TX_START: begin
               txBit_q <= 4'h0;
               txState_q <= scw_pkg::TX_DATA;
            end
            scw_pkg::TX_DATA: begin
               txShift_q <= {1'b1, txShift_q[8:1]};
               txBit_q <= txBit_q + 4'h1;
               if (txBit_q == dataBits - 4'h1) begin
                  txState_q <= scw_pkg::TX_STOP;
               end
            end
            scw_pkg::TX_STOP: txState_q <= scw_pkg::TX_IDLE;
         endcase
      end
   end

   // clock pulse only inside data bits; last one optional
   assign pulse = (txState_q == scw_pkg::TX_DATA) &
      ((txBit_q != dataBits - 4'h1) | fmt_q[scw_pkg::F_LAST]) &
      (fmt_q[scw_pkg::F_PHA] ? (txCnt_q < HALF_CNT) :
                               (txCnt_q >= HALF_CNT));

   // pins registered; float once disabled and the character is done
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         txLine_q <= 1'b1;
         sclk_q <= 1'b0;
         oe_q <= 1'b0;
      end else begin
         oe_q <= txOn | (txState_q != scw_pkg::TX_IDLE);
         sclk_q <= fmt_q[scw_pkg::F_POL] ^ pulse;
         unique case (txState_q)
            scw_pkg::TX_BRK, scw_pkg::TX_START: txLine_q <= 1'b0;
            scw_pkg::TX_DATA: txLine_q <= txShift_q[0];
            default: txLine_q <= 1'b1;
         endcase
      end
   end
   assign serialOutPin = txLine_q;
   assign sclkOut = sclk_q;
   assign serialOutEn = oe_q;
   assign sclkOutEn = oe_q;

   // transmit flags; a set in the clear cycle wins
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         txEmpty_q <= 1'b1;
         txDone_q <= 1'b1;
      end else begin
         if (txLoad) begin
            txEmpty_q <= 1'b1;
         end else if (wrData & statRead_q) begin
            txEmpty_q <= 1'b0;
         end
         if (txIdleNow & txTick & ~preReq_q & ~brk) begin
            txDone_q <= 1'b1;
         end else if (wrData & statRead_q) begin
            txDone_q <= 1'b0;
         end
      end
   end

   // ---------------- receiver ----------------
   scw_pkg::scw_rx_type rxState_q;
   logic [CW-1:0] rxCnt_q;
   logic [3:0] rxBit_q;
   logic [8:0] rxShift_q, rxWord;
   logic [15:0] quietCnt_q, quietLimit;
   logic rxNoise_q, rxArm_q, lineIn, vote, noisy, evalPt, frameEnd;
   logic lastBit, wakeAddr, accept, idleEvent, idleNow;

   // two flops before any logic sees the pin
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         inSync_q <= 2'b11;
         samp_q <= 3'b111;
      end else begin
         inSync_q <= {inSync_q[0], serialInPin};
         samp_q <= {samp_q[1:0], inSync_q[1]};
      end
   end
   assign lineIn = inSync_q[1];
   // three samples around the bit centre, majority vote
   assign vote = (samp_q[0] & samp_q[1]) | (samp_q[1] & samp_q[2]) |
      (samp_q[0] & samp_q[2]);
   assign noisy = ~(&samp_q) & (|samp_q);
   assign evalPt = (rxCnt_q == MID_CNT);
   assign frameEnd = evalPt & (rxState_q == scw_pkg::RX_STOP);
   assign rxWord = nine ? rxShift_q : {1'b0, rxShift_q[8:1]};
   assign lastBit = nine ? rxWord[8] : rxWord[7];
   assign wakeAddr = sleep & wake & lastBit;
   assign accept = frameEnd & rxOn & (~sleep | wakeAddr);

   // bit framing; after a break the line must go high before a start
   always_ff @(posedge clk_sys) begin
      if (!rstn || !rxOn) begin
         rxState_q <= scw_pkg::RX_IDLE;
         rxCnt_q <= '0;
         rxBit_q <= 4'h0;
         rxShift_q <= 9'h0;
         rxNoise_q <= 1'b0;
         rxArm_q <= 1'b0;
      end else begin
         rxCnt_q <= (rxCnt_q == LAST_CNT) ? '0 : rxCnt_q + 1'b1;
         unique case (rxState_q)
            scw_pkg::RX_IDLE: begin
               rxCnt_q <= '0;
               rxBit_q <= 4'h0;
               if (lineIn) begin
                  rxArm_q <= 1'b1;
               end else if (rxArm_q) begin
                  rxState_q <= scw_pkg::RX_START;
                  rxNoise_q <= 1'b0;
               end
            end
            scw_pkg::RX_START: if (evalPt) begin
               rxNoise_q <= noisy;
               if (vote) begin
                  rxState_q <= scw_pkg::RX_IDLE; // false start
               end
            end
            scw_pkg::RX_DATA: if (evalPt) begin
               rxShift_q <= {vote, rxShift_q[8:1]};
               rxNoise_q <= rxNoise_q | noisy;
               rxBit_q <= rxBit_q + 4'h1;
               if (rxBit_q == dataBits - 4'h1) begin
                  rxState_q <= scw_pkg::RX_STOP;
               end
            end
            scw_pkg::RX_STOP: if (evalPt) begin
               rxState_q <= scw_pkg::RX_IDLE;
               rxArm_q <= vote;
            end
         endcase
         if (rxState_q == scw_pkg::RX_START && evalPt && !vote) begin
            rxState_q <= scw_pkg::RX_DATA;
         end
      end
   end

   // idle is a full frame of high bit times
   assign quietLimit = 16'(frameBits) * 16'(BIT_CLKS);
   assign idleNow = (quietCnt_q == quietLimit);
   assign idleEvent = lineIn & (quietCnt_q == quietLimit - 16'h1);
   always_ff @(posedge clk_sys) begin
      if (!rstn || !lineIn) begin
         quietCnt_q <= 16'h0;
      end else if (!idleNow) begin
         quietCnt_q <= quietCnt_q + 16'h1;
      end
   end

   // receive data, ninth bit and error flags in one transfer
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rxData_q <= 8'h0;
         rxNinth_q <= 1'b0;
         rxFull_q <= 1'b0;
         ovr_q <= 1'b0;
         noise_q <= 1'b0;
         frame_q <= 1'b0;
      end else if (accept & (rxFull_q | frame_q)) begin
         ovr_q <= 1'b1; // no transfer while full or framing held
      end else if (accept) begin
         rxData_q <= rxWord[7:0];
         rxNinth_q <= rxWord[8];
         rxFull_q <= 1'b1;
         noise_q <= rxNoise_q | noisy;
         frame_q <= ~vote;
      end else if (rdData & statRead_q) begin
         rxFull_q <= 1'b0;
         ovr_q <= 1'b0;
         noise_q <= 1'b0;
         frame_q <= 1'b0;
      end
   end

   // idle flag rearms only after a character arrives
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         quiet_q <= 1'b0;
         quietArm_q <= 1'b1;
      end else begin
         if (idleEvent & rxOn & ~sleep & quietArm_q) begin
            quiet_q <= 1'b1;
            quietArm_q <= 1'b0;
         end else if (rdData & statRead_q) begin
            quiet_q <= 1'b0;
         end
         if (accept) begin
            quietArm_q <= 1'b1;
         end
      end
   end

   // control registers; hardware wake clears sleep, a write wins
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         fmt_q <= scw_pkg::FORMAT_RESET;
         ena_q <= scw_pkg::ENABLES_RESET;
         txData_q <= 8'h0;
      end else begin
         if (wrFmt) begin
            fmt_q <= {1'b0, wdata[6:0]};
         end
         if (wrData) begin
            txData_q <= wdata[7:0];
         end
         if (sleep & ~wake & idleEvent) begin
            ena_q[scw_pkg::E_SLEEP] <= 1'b0;
         end else if (frameEnd & wakeAddr) begin
            ena_q[scw_pkg::E_SLEEP] <= 1'b0;
         end
         if (wrEna) begin
            ena_q <= wdata[7:0];
            // sleeping is refused on an idle line in idle wake mode
            if (~wake & idleNow & ~sleep) begin
               ena_q[scw_pkg::E_SLEEP] <= 1'b0;
            end
         end
      end
   end

   // single request from the gated sources
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         irqReq <= 1'b0;
      end else begin
         irqReq <= (ena_q[scw_pkg::E_TXIE] & txEmpty_q) |
            (ena_q[scw_pkg::E_TX_DONE_IRQ_EN] & txDone_q) |
            (ena_q[scw_pkg::E_RXIE] & (rxFull_q | ovr_q)) |
            (ena_q[scw_pkg::E_LINE_QUIET_IRQ_EN] & quiet_q);
      end
   end
endmodule

// >>> verif/scw_uart_monitor.sv
`timescale 1ns/100ps
module scw_uart_monitor #(
   parameter int BIT_CLKS = 16
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [31:0] wdata,
   input wire logic wvalid,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic serialOutPin,
   input wire logic serialOutEn,
   input wire logic sclkOut,
   input wire logic sclkOutEn,
   input wire logic irqReq
);
   logic [7:0] fmt_q;
   logic [7:0] en_q;
   logic [9:0] sinceEn_q;
   logic mapped;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // decoded read address
   assign mapped = araddr[7:2] inside {scw_pkg::IDX_STATUS,
      scw_pkg::IDX_FORMAT, scw_pkg::IDX_ENABLES, scw_pkg::IDX_DATA};
   // shadow of control writes; bench always writes whole words
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         fmt_q <= 8'h00;
         en_q <= 8'h00;
      end else if (awvalid && awready && wvalid) begin
         if (awaddr[7:2] == scw_pkg::IDX_FORMAT) fmt_q <= wdata[7:0];
         if (awaddr[7:2] == scw_pkg::IDX_ENABLES) en_q <= wdata[7:0];
      end
   end
   // cycles since pins enabled, saturating
   always_ff @(posedge clk_sys) begin
      if (!rstn || !serialOutEn) sinceEn_q <= 10'h000;
      else if (sinceEn_q != 10'h3ff) sinceEn_q <= sinceEn_q + 10'h001;
   end
   a_wr_answer: assert property (awvalid && awready && wvalid |=> bvalid)
      else $error("write not answered");
   a_b_hold: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped");
   a_rd_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read not answered");
   a_rd_hold: assert property (rvalid && !rready |=> rvalid
      && $stable(rdata) && $stable(rresp)) else $error("read data moved");
   a_bad_addr: assert property (arvalid && arready && !mapped |=>
      rresp == scw_pkg::RESP_SLVERR && rdata == 32'h0)
      else $error("unmapped read accepted");
   a_en_pair: assert property (sclkOutEn == serialOutEn)
      else $error("pin enables differ");
   a_pins_on: assert property (en_q[scw_pkg::E_TXON] &&
      $past(en_q[scw_pkg::E_TXON]) |-> serialOutEn)
      else $error("pins not driven");
   a_pre_len: assert property ($fell(serialOutPin) && serialOutEn
      |-> sinceEn_q >= (fmt_q[scw_pkg::F_NINE] ? 11 : 10) * BIT_CLKS - 2)
      else $error("preamble short");
   a_pre_quiet: assert property (serialOutEn
      && sinceEn_q < 9 * BIT_CLKS |-> sclkOut == fmt_q[scw_pkg::F_POL])
      else $error("clock moved in preamble");
   a_irq_gate: assert property (en_q[7:4] == 4'h0
      && $past(en_q[7:4]) == 4'h0 |-> !irqReq)
      else $error("request with sources off");
   c_start: cover property ($fell(serialOutPin) && serialOutEn);
   c_irq: cover property ($rose(irqReq));
   c_pulse: cover property ($changed(sclkOut) && sclkOutEn);
endmodule

bind scw_uart scw_uart_monitor #(.BIT_CLKS(BIT_CLKS)) mon (
   .clk_sys(clk_sys), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid),
   .awready(awready), .wdata(wdata), .wvalid(wvalid), .bvalid(bvalid),
   .bready(bready), .araddr(araddr), .arvalid(arvalid),
   .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
   .rready(rready), .serialOutPin(serialOutPin),
   .serialOutEn(serialOutEn), .sclkOut(sclkOut), .sclkOutEn(sclkOutEn),
   .irqReq(irqReq));

// >>> verif/scw_uart_peer.sv
`timescale 1ns/100ps
module scw_uart_peer #(
   parameter int BIT_CLKS = 16
) (
   input wire logic clk_sys,
   input wire logic serialOutPin,
   input wire logic serialOutEn,
   input wire logic sclkOut,
   input wire logic nine,
   output logic serialInPin,
   output logic gotStb,
   output logic [13:0] got
);
   logic [4:0] tog;
   logic [8:0] w;
   logic stopBit;
   int i;
   initial begin
      serialInPin = 1'b1;
      gotStb = 1'b0;
      got = 14'h0;
      tog = 5'h0;
   end
   // two edges per clock pulse
   always @(sclkOut) if (serialOutEn) tog = tog + 5'h1;
   // receive at bit centres, 2 ns off the edge to dodge races
   always begin
      @(negedge serialOutPin iff serialOutEn);
      tog = 5'h0;
      w = 9'h0;
      #(BIT_CLKS * 4 + 2);
      for (i = 0; i < (nine ? 9 : 8); i++) begin
         #(BIT_CLKS * 8);
         w[i] = serialOutPin;
      end
      #(BIT_CLKS * 8);
      stopBit = serialOutPin;
      got = {stopBit, tog[4:1], w};
      gotStb = 1'b1;
      #1 gotStb = 1'b0;
      if (!stopBit) wait (serialOutPin);
   end
   // link bits of 125 ns, half a ns off the system grid
   task send(input logic [8:0] d);
      int j;
      @(posedge clk_sys);
      #0.5 serialInPin = 1'b0;
      for (j = 0; j < (nine ? 9 : 8); j++) begin
         #125 serialInPin = d[j];
      end
      #125 serialInPin = 1'b1;
      #125;
   endtask
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   localparam int BC = 16;
   logic clk_sys = 1'b0, rstn = 1'b0, nine = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, v, d;
   logic [31:0] wdata = 32'h0, rdata, r;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, serialInPin, gotStb;
   logic serialOutPin, serialOutEn, sclkOut, sclkOutEn, irqReq;
   logic [1:0] bresp, rresp;
   logic [13:0] got;
   logic [9:0] rdExp[$], rdMsk[$];
   logic [13:0] serExp[$];
   int n_fail = 0, n_tests = 0, k;
   always #4 clk_sys = ~clk_sys;
   scw_uart #(.BIT_CLKS(BC)) dut (.clk_sys(clk_sys), .rstn(rstn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .serialInPin(serialInPin),
      .serialOutPin(serialOutPin), .serialOutEn(serialOutEn),
      .sclkOut(sclkOut), .sclkOutEn(sclkOutEn), .irqReq(irqReq));
   scw_uart_peer #(.BIT_CLKS(BC)) peer (.clk_sys(clk_sys),
      .serialOutPin(serialOutPin), .serialOutEn(serialOutEn),
      .sclkOut(sclkOut), .nine(nine), .serialInPin(serialInPin),
      .gotStb(gotStb), .got(got));
   task chk(input logic [13:0] g, input logic [13:0] e,
      input logic [13:0] m);
      n_tests++;
      if ((g & m) !== (e & m)) begin
         n_fail++;
         $display("wrong value at %0t: %h, want %h", $time, g, e);
      end
   endtask
   // one write, both channels offered together
   task wr(input logic [7:0] a, input logic [7:0] x);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= {24'h0, x};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(negedge clk_sys); while (!(awready && wready));
      @(posedge clk_sys);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(negedge clk_sys); while (!bvalid);
      @(posedge clk_sys);
      bready <= 1'b0;
   endtask
   // one read; expectation noted for the watcher
   task rd(input logic [7:0] a, input logic [9:0] e, input logic [9:0] m);
      rdExp.push_back(e);
      rdMsk.push_back(m);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge clk_sys); while (!arready);
      @(posedge clk_sys);
      arvalid <= 1'b0;
      do @(negedge clk_sys); while (!rvalid);
      v = rdata[7:0];
      @(posedge clk_sys);
      rready <= 1'b0;
   endtask
   task stop_test;
      $display("%0d mismatches in %0d checks", n_fail, n_tests);
      if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // watchers pop the oldest note per result
   always @(posedge clk_sys) begin
      if (rvalid && rready && rdExp.size() > 0)
         chk({4'h0, rresp, rdata[7:0]}, rdExp.pop_front(), rdMsk.pop_front());
      // every write the bench makes is to a mapped register
      if (bvalid && bready)
         chk({12'h0, bresp}, 14'h0, 14'h3);
   end
   always @(posedge gotStb)
      chk(got, serExp.size() > 0 ? serExp.pop_front() : ~got, 14'h3fff);
   initial begin
      #300000;
      n_fail++;
      stop_test;
   end
   initial begin
      void'($urandom(32'h93a9));
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(8'h38, 10'h000, 10'h3ff);
      rd(8'h3c, 10'h000, 10'h3ff);
      rd(8'h40, 10'h0c0, 10'h3ff);
      rd(8'h24, 10'h200, 10'h3ff);
      $display("register test done");
      // every framing and last-clock pairing, random polarity and phase
      for (k = 0; k < 5; k++) begin
         r = $urandom;
         d = {1'b0, r[6], 1'b0, k[1], 1'b0, r[2:1], k[0]};
         nine <= k[1];
         wr(8'h38, d);
         wr(8'h3c, 8'h08);
         if (k == 4) begin
            repeat (11 * BC) @(posedge clk_sys);
            serExp.push_back(14'h0);
            wr(8'h3c, 8'h09);
            repeat (2 * BC) @(posedge clk_sys);
            wr(8'h3c, 8'h08);
         end
         serExp.push_back({1'b1, 4'(7 + k[1] + k[0]), k[1] & r[6],
            r[15:8]});
         rd(8'h40, 10'h0, 10'h0);
         wr(8'h44, r[15:8]);
         do rd(8'h40, 10'h0, 10'h0); while (!v[7]);
         wr(8'h38, d ^ 8'h08);
         rd(8'h38, {2'h0, d ^ 8'h08}, 10'h07f);
         wr(8'h3c, 8'h00);
         repeat (4000) if (serExp.size() > 0) @(posedge clk_sys);
         // a frame that never arrives must not pass silently
         if (serExp.size() > 0) begin
            n_fail++;
            serExp.delete();
         end
         repeat (2 * BC) @(posedge clk_sys);
         $display("transmit test %0d done", k);
      end
      // receive in both framings, then with the receiver off
      for (k = 0; k < 3; k++) begin
         r = $urandom;
         nine <= k[0];
         wr(8'h38, {3'h0, k[0], 4'h0});
         wr(8'h3c, (k == 2) ? 8'h20 : 8'h24);
         peer.send(r[8:0]);
         repeat (4) @(posedge clk_sys);
         rd(8'h40, {4'h0, k[1] ? 1'b0 : 1'b1, 5'h0}, 10'h020);
         @(negedge clk_sys);
         chk({13'h0, irqReq}, {13'h0, !k[1]}, 14'h1);
         rd(8'h38, {2'h0, k[0] & r[8], 7'h0}, {2'h0, !k[1], 7'h0});
         rd(8'h44, {2'h0, r[7:0]}, {2'h0, {8{!k[1]}}});
         repeat (3) @(posedge clk_sys);
         @(negedge clk_sys);
         chk({13'h0, irqReq}, 14'h0, 14'h1);
         $display("receive test %0d done", k);
      end
      nine <= 1'b0;
      wr(8'h3c, 8'h04);
      repeat (12 * BC) @(posedge clk_sys);
      wr(8'h3c, 8'h06);
      rd(8'h3c, 10'h004, 10'h006);
      wr(8'h38, 8'h08);
      wr(8'h3c, 8'h06);
      peer.send({2'h0, r[6:0]});
      repeat (4) @(posedge clk_sys);
      rd(8'h40, 10'h000, 10'h020);
      peer.send({2'h1, r[6:0]});
      repeat (4) @(posedge clk_sys);
      rd(8'h40, 10'h020, 10'h020);
      rd(8'h3c, 10'h004, 10'h002);
      rd(8'h44, {3'h1, r[6:0]}, 10'h0ff);
      $display("wake test done");
      stop_test;
   end
endmodule
